// [hw/amc_regs.svh]
/*
  Register offsets, field positions and timing constants of the multiplexed
  converter control block. Assumes byte offsets on the module I/O space.
*/
`ifndef AMC_REGS_SVH
`define AMC_REGS_SVH

// Register byte offsets in module I/O space
`define AMC_OFS_SETUP      8'h00
`define AMC_OFS_RESULT     8'h02
`define AMC_OFS_FLAGS      8'h05
`define AMC_OFS_TRIGGER    8'h07
`define AMC_OFS_VECTOR     8'h09
`define AMC_OFS_IDUNLOCK   8'h0b

// Setup register fields
`define AMC_BIT_IRQ_GATE   9
`define AMC_BIT_DELAY_SEL  8
`define AMC_BIT_AUTO_SEL   7
`define AMC_BIT_DIFF_SEL   4
`define AMC_GAIN_HI        6
`define AMC_GAIN_LO        5
`define AMC_SEL_HI         3
`define AMC_SEL_LO         0
`define AMC_SETUP_KEEP     16'h03ff

// Flags register fields
`define AMC_BIT_CONV_BUSY  1
`define AMC_BIT_SETL_BUSY  0

// Vector register fields; bit 0 carries the request source
`define AMC_VEC_HI         7
`define AMC_VEC_LO         1

// Reset values
`define AMC_RST_16         16'h0000
`define AMC_RST_8          8'h00

// Settling time and clock period in ns
`define AMC_SETTLE_NS      10000
`define AMC_CLK_PERIOD_NS  25
`define AMC_SETTLE_CYCLES  ((`AMC_SETTLE_NS + `AMC_CLK_PERIOD_NS - 1) / `AMC_CLK_PERIOD_NS)

`endif

// [hw/amc_pkg.sv]
/*
  Types of the multiplexed converter control block.
  Assumes the constants header is included by users that need numbers.
*/
package amc_pkg;

  // Conversion sequencer states, one-hot
  typedef enum logic [3:0]
  {
    AMC_IDLE   = 4'b0001,
    AMC_SETTLE = 4'b0010,
    AMC_LAUNCH = 4'b0100,
    AMC_CONV   = 4'b1000
  } amc_state_t;

endpackage : amc_pkg

// [hw/amc_settle_timer.sv]
/*
  Settling interval timer: restarts on every setup write, reports busy.
  Assumes a synchronous active-high reset and one clock domain.
*/
`timescale 1ns/1ps
`include "amc_regs.svh"

module amc_settle_timer #(
  parameter int CYCLES = `AMC_SETTLE_CYCLES
) (
  input  wire logic i_clock,   // Module bus clock
  input  wire logic i_srst,    // Synchronous reset
  input  wire logic i_restart, // Setup register written
  output logic      o_busy     // Settling in progress
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] count_reg;

  ////////////////////////////////////////////////////////////////////
  // Counter reloads on each restart, so back-to-back writes extend it
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      count_reg <= '0;
      o_busy    <= 1'b0;
    end
    else if (i_restart)
    begin
      count_reg <= CW'(CYCLES - 1);
      o_busy    <= 1'b1;
    end
    else if (o_busy)
    begin
      if (count_reg == '0)
        o_busy <= 1'b0;
      else
        count_reg <= count_reg - CW'(1);
    end
  end

endmodule : amc_settle_timer

// [hw/amc_control.sv]
/*
  Host-visible control logic of a 16-input multiplexed converter module:
  setup, result, flags, trigger and vector registers, settling timer,
  conversion sequencer and two interrupt requests with acknowledge.
  Assumes a byte-wide I/O space with one-cycle read/write strobes on the
  module clock, an external converter with start/done handshake on the
  same clock, and a host that keeps its own ordering duties.
*/
`timescale 1ns/1ps
`include "amc_regs.svh"

module amc_control #(
  parameter int SETTLE_CYCLES = `AMC_SETTLE_CYCLES
) (
  input  wire logic        i_clock,      // Module bus clock, 40 MHz
  input  wire logic        i_srst,       // Bus reset, synchronous
  input  wire logic [7:0]  i_addr,       // I/O space byte address
  input  wire logic        i_wr,         // Write strobe, one cycle
  input  wire logic        i_rd,         // Read strobe, one cycle
  input  wire logic [15:0] i_wdata,      // Write data
  output logic      [15:0] o_rdata,      // Read data, registered
  input  wire logic        i_ack,        // Interrupt acknowledge strobe
  input  wire logic        i_ack_level,  // Level acknowledged: 1 = request 1
  output logic      [7:0]  o_vector,     // Vector answer, registered
  output logic             o_irq0,       // Conversion done request, high
  output logic             o_irq1,       // Settling done request, high
  output logic             o_conv_start, // Launch pulse to converter
  input  wire logic        i_conv_done,  // Converter sample complete pulse
  input  wire logic [15:0] i_conv_data,  // Converter sample data
  output logic      [1:0]  o_gain,       // Amplifier gain code
  output logic             o_diff,       // Differential input mode
  output logic      [3:0]  o_input_sel   // Multiplexer input select
);

  logic [15:0]         adc_setup_reg;
  logic [15:0]         conversion_result_reg;
  logic [15:0]         prev_sample_reg;
  logic [7:0]          irq_vector_base_reg;
  logic                conv_busy_reg;
  logic                settle_busy;
  logic                settle_busy_d_reg;
  logic                conv_busy_d_reg;
  logic                pend0_reg;
  logic                pend1_reg;
  amc_pkg::amc_state_t state_reg;

  logic wr_setup;
  logic wr_trigger;
  logic wr_vector;
  logic irq_gate;
  logic auto_settle_select;
  logic result_delay_select;
  logic settle_fall;
  logic conv_fall;
  logic start_auto;
  logic start_normal;
  logic wr_result;
  logic [7:0] flags_image;

  ////////////////////////////////////////////////////////////////////
  // Address decode, used for both reads and writes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // Write strobes per register; unlock writes are swallowed
  assign wr_setup   = i_wr && hit(i_addr, `AMC_OFS_SETUP);
  assign wr_trigger = i_wr && hit(i_addr, `AMC_OFS_TRIGGER);
  assign wr_vector  = i_wr && hit(i_addr, `AMC_OFS_VECTOR);
  assign wr_result  = i_wr && hit(i_addr, `AMC_OFS_RESULT);

  // Conversion requests, shared by sequencer and busy flag so the two
  // can never disagree on whether a write started something
  assign start_auto   = wr_setup && i_wdata[`AMC_BIT_AUTO_SEL];
  assign start_normal = wr_trigger && !auto_settle_select;

  // Setup field views
  assign irq_gate            = adc_setup_reg[`AMC_BIT_IRQ_GATE];
  assign result_delay_select = adc_setup_reg[`AMC_BIT_DELAY_SEL];
  assign auto_settle_select  = adc_setup_reg[`AMC_BIT_AUTO_SEL];

  ////////////////////////////////////////////////////////////////////
  // Setup register; upper bits are never stored
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      adc_setup_reg <= `AMC_RST_16;
    else if (wr_setup)
      adc_setup_reg <= i_wdata & `AMC_SETUP_KEEP;
  end

  // Front-end controls follow the stored setup
  assign o_gain      = adc_setup_reg[`AMC_GAIN_HI:`AMC_GAIN_LO];
  assign o_diff      = adc_setup_reg[`AMC_BIT_DIFF_SEL];
  // Differential mode only has eight pairs, so the top select bit is masked
  assign o_input_sel = {adc_setup_reg[`AMC_SEL_HI] & ~o_diff,
                        adc_setup_reg[`AMC_SEL_HI-1:`AMC_SEL_LO]};

  ////////////////////////////////////////////////////////////////////
  // Vector base; bit 0 is never stored so reads show zero there
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      irq_vector_base_reg <= `AMC_RST_8;
    else if (wr_vector)
      irq_vector_base_reg <= {i_wdata[`AMC_VEC_HI:`AMC_VEC_LO], 1'b0};
  end

  ////////////////////////////////////////////////////////////////////
  // Settling timer, same interval whatever the gain
  amc_settle_timer #(
    .CYCLES    (SETTLE_CYCLES)
  ) u_settle (
    .i_clock   (i_clock),
    .i_srst    (i_srst),
    .i_restart (wr_setup),
    .o_busy    (settle_busy)
  );

  ////////////////////////////////////////////////////////////////////
  // Conversion sequencer
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      state_reg <= amc_pkg::AMC_IDLE;
    else
    begin
      case (state_reg)
        amc_pkg::AMC_IDLE:
        begin
          if (start_auto)
            state_reg <= amc_pkg::AMC_SETTLE;
          else if (start_normal)
            state_reg <= amc_pkg::AMC_LAUNCH;
        end
        amc_pkg::AMC_SETTLE:
        begin
          // Launch waits until the settling counter has expired
          if (!settle_busy && !wr_setup)
            state_reg <= amc_pkg::AMC_LAUNCH;
        end
        amc_pkg::AMC_LAUNCH:
          state_reg <= amc_pkg::AMC_CONV;
        amc_pkg::AMC_CONV:
        begin
          if (i_conv_done)
            state_reg <= amc_pkg::AMC_IDLE;
        end
        default:
          state_reg <= amc_pkg::AMC_IDLE;
      endcase
    end
  end

  // Launch pulse comes out of the launch state
  assign o_conv_start = (state_reg == amc_pkg::AMC_LAUNCH);

  ////////////////////////////////////////////////////////////////////
  // Converter busy: covers settling in auto mode, ignores busy triggers
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      conv_busy_reg <= 1'b0;
    else if (state_reg == amc_pkg::AMC_IDLE)
    begin
      if (start_auto)
        conv_busy_reg <= 1'b1;
      else if (start_normal)
        conv_busy_reg <= 1'b1;
    end
    else if (state_reg == amc_pkg::AMC_CONV && i_conv_done)
      conv_busy_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // Result register; pipeline mode shows the sample before this one
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      conversion_result_reg <= `AMC_RST_16;
      prev_sample_reg       <= `AMC_RST_16;
    end
    else if (state_reg == amc_pkg::AMC_CONV && i_conv_done)
    begin
      prev_sample_reg <= i_conv_data;
      if (result_delay_select)
        conversion_result_reg <= prev_sample_reg;
      else
        conversion_result_reg <= i_conv_data;
    end
    else if (wr_result)
      conversion_result_reg <= i_wdata;
  end

  ////////////////////////////////////////////////////////////////////
  // Edge detection of both busy flags
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      settle_busy_d_reg <= 1'b0;
      conv_busy_d_reg   <= 1'b0;
    end
    else
    begin
      settle_busy_d_reg <= settle_busy;
      conv_busy_d_reg   <= conv_busy_reg;
    end
  end

  assign settle_fall = settle_busy_d_reg && !settle_busy;
  assign conv_fall   = conv_busy_d_reg && !conv_busy_reg;

  ////////////////////////////////////////////////////////////////////
  // Set wins over clear, so an edge in the acknowledge cycle is never lost
  function automatic logic next_pending(input logic pend, input logic raise, input logic drop);
    if (raise)
      next_pending = 1'b1;
    else if (drop)
      next_pending = 1'b0;
    else
      next_pending = pend;
  endfunction : next_pending

  // Pending requests; a new edge in the acknowledge cycle wins
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      pend0_reg <= 1'b0;
      pend1_reg <= 1'b0;
    end
    else
    begin
      pend0_reg <= next_pending(pend0_reg, conv_fall && irq_gate, i_ack && !i_ack_level);
      pend1_reg <= next_pending(pend1_reg, settle_fall && irq_gate && !auto_settle_select,
                                i_ack && i_ack_level);
    end
  end

  // Gate withdraws requests immediately when cleared
  assign o_irq0 = pend0_reg && irq_gate;
  assign o_irq1 = pend1_reg && irq_gate;

  ////////////////////////////////////////////////////////////////////
  // Acknowledge answer: base with source bit appended
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      o_vector <= `AMC_RST_8;
    else if (i_ack)
      o_vector <= {irq_vector_base_reg[`AMC_VEC_HI:`AMC_VEC_LO], i_ack_level};
  end

  ////////////////////////////////////////////////////////////////////
  // Flags image; undefined bits read zero rather than floating
  always_comb
  begin
    flags_image                     = `AMC_RST_8;
    flags_image[`AMC_BIT_CONV_BUSY] = conv_busy_reg;
    flags_image[`AMC_BIT_SETL_BUSY] = settle_busy;
  end

  ////////////////////////////////////////////////////////////////////
  // Read data; unmapped and write-only addresses read zero
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      o_rdata <= `AMC_RST_16;
    else if (i_rd)
    begin
      if (hit(i_addr, `AMC_OFS_SETUP))
        o_rdata <= adc_setup_reg;
      else if (hit(i_addr, `AMC_OFS_RESULT))
        o_rdata <= conversion_result_reg;
      else if (hit(i_addr, `AMC_OFS_FLAGS))
        o_rdata <= {`AMC_RST_8, flags_image};
      else if (hit(i_addr, `AMC_OFS_VECTOR))
        o_rdata <= {`AMC_RST_8, irq_vector_base_reg};
      else
        o_rdata <= `AMC_RST_16;
    end
  end

endmodule : amc_control

// [sim/amc_control_monitor.sv]
/* Port checker of the converter control block.
   Sees only the top ports; bound from the bench top file. */
`timescale 1ns/1ps
module amc_control_monitor #(
  parameter int SETTLE_CYCLES = 400
) (
  input wire logic        i_clock,      // Clock
  input wire logic        i_srst,       // Reset
  input wire logic [7:0]  i_addr,       // Address
  input wire logic        i_wr,         // Write
  input wire logic        i_rd,         // Read
  input wire logic [15:0] i_wdata,      // Write data
  input wire logic [15:0] o_rdata,      // Read data
  input wire logic        i_ack,        // Ack strobe
  input wire logic        i_ack_level,  // Ack level
  input wire logic [7:0]  o_vector,     // Vector
  input wire logic        o_irq0,       // Request 0
  input wire logic        o_irq1,       // Request 1
  input wire logic        o_conv_start, // Launch
  input wire logic        i_conv_done,  // Sample done
  input wire logic [15:0] i_conv_data,  // Sample
  input wire logic [1:0]  o_gain,       // Gain
  input wire logic        o_diff,       // Diff mode
  input wire logic [3:0]  o_input_sel   // Input select
);
  logic        gate_reg;  // Request gate shadow
  logic        auto_reg;  // Auto mode shadow
  logic        run_reg;   // Conversion in flight
  logic [7:0]  vec_reg;   // Vector base shadow
  logic [15:0] since_reg; // Cycles since setup write
  wire         setup_wr = i_wr && i_addr == 8'h00;

  // Shadows of the fields that shape outputs
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      gate_reg <= 1'b0;
      auto_reg <= 1'b0;
      vec_reg  <= 8'h00;
    end
    else
    begin
      if (setup_wr)
      begin
        gate_reg <= i_wdata[9];
        auto_reg <= i_wdata[7];
      end
      if (i_wr && i_addr == 8'h09)
        vec_reg <= i_wdata[7:0];
    end
  end

  // Saturates so a long idle spell never wraps
  always_ff @(posedge i_clock)
  begin
    if (i_srst || setup_wr)
      since_reg <= 16'h0000;
    else if (since_reg != 16'hffff)
      since_reg <= since_reg + 16'h0001;
  end

  // From launch to the converter's done pulse
  always_ff @(posedge i_clock)
  begin
    if (i_srst || i_conv_done)
      run_reg <= 1'b0;
    else if (o_conv_start)
      run_reg <= 1'b1;
  end

  ////////////////////////////////////////
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_srst);

  a_reset_clears:
    assert property (disable iff (1'b0) i_srst |=> !o_irq0 && !o_irq1 && !o_conv_start && !o_diff
      && o_gain == 2'h0 && o_input_sel == 4'h0) else $error("outputs not cleared by reset");
  a_gain_diff_follow:
    assert property (setup_wr |=> o_gain == $past(i_wdata[6:5]) && o_diff == $past(i_wdata[4]))
    else $error("gain or input mode not taken from setup");
  a_input_sel_follow:
    assert property (setup_wr |=> o_input_sel == {$past(i_wdata[3] & ~i_wdata[4]), $past(i_wdata[2:0])})
    else $error("input select wrong");
  a_gate_masks_irq:
    assert property (!gate_reg |-> !o_irq0 && !o_irq1) else $error("request while gate closed");
  a_auto_no_settle:
    assert property ($rose(o_irq1) && $past(gate_reg) |-> !auto_reg) else $error("settle request in auto mode");
  a_auto_waits_settle:
    assert property (o_conv_start && auto_reg |-> since_reg >= SETTLE_CYCLES - 1)
    else $error("auto launch before settling");
  a_busy_trigger_ignored:
    assert property (i_wr && i_addr == 8'h07 && (run_reg || o_conv_start) |=> !o_conv_start)
    else $error("trigger taken while busy");
  a_done_raises_irq0:
    assert property (i_conv_done && run_reg && gate_reg && !i_ack |-> ##2 o_irq0)
    else $error("no conversion request after done");
  a_start_one_cycle:
    assert property (o_conv_start |=> !o_conv_start) else $error("launch longer than one cycle");
  a_vector_answer:
    assert property (i_ack |=> o_vector == {vec_reg[7:1], $past(i_ack_level)}) else $error("vector wrong");
endmodule : amc_control_monitor

// [sim/amc_conv_model.sv]
/* Behavioural external converter on the launch/done pair.
   Assumes launches arrive only while it is idle. */
`timescale 1ns/1ps
module amc_conv_model (
  input  wire logic        i_clock,  // Clock
  input  wire logic        i_start,  // Launch pulse
  input  wire logic [3:0]  i_lag,    // Extra cycles to done
  input  wire logic [15:0] i_sample, // Value returned
  output logic             o_done,   // Done pulse
  output logic      [15:0] o_data    // Sample bus
);
  logic [4:0] cnt_reg; // Cycles left, 0 when idle

  initial
  begin
    o_done = 1'b0;
    o_data = 16'h0000;
    cnt_reg = 5'h00;
  end

  // Bus toggles when not valid so stale data cannot pass
  always @(posedge i_clock)
  begin
    o_done <= (cnt_reg == 5'h01);
    o_data <= (cnt_reg == 5'h01) ? i_sample : ~o_data;
    if (i_start)
      cnt_reg <= {1'b0, i_lag} + 5'h01;
    else if (cnt_reg != 5'h00)
      cnt_reg <= cnt_reg - 5'h01;
  end
endmodule : amc_conv_model

// [sim/tb.sv]
/* Self-checking bench of the converter control block.
   Assumes one-cycle strobes and a 40 MHz clock. */
`timescale 1ns/1ps
module tb;
  localparam int SETTLE = 8; // Shortened settling count
  logic        i_clock, i_srst, i_wr, i_rd, i_ack, i_ack_level;
  logic        o_irq0, o_irq1, o_conv_start, i_conv_done, o_diff;
  logic [7:0]  i_addr, o_vector;
  logic [15:0] i_wdata, o_rdata, i_conv_data, sample, prev, r, d;
  logic [1:0]  o_gain;
  logic [3:0]  o_input_sel, lag;
  int          fail_count, n_tests, starts, seed, n, s0;
  logic [7:0]  rst_addr [6] = '{8'h00, 8'h02, 8'h05, 8'h07, 8'h09, 8'h0c};
  logic [15:0] runs [5] = '{16'h0203, 16'h0315, 16'h0380, 16'h0287, 16'h0000};

  amc_control #(.SETTLE_CYCLES(SETTLE)) dut (.i_clock(i_clock), .i_srst(i_srst), .i_addr(i_addr),
    .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_ack(i_ack),
    .i_ack_level(i_ack_level), .o_vector(o_vector), .o_irq0(o_irq0), .o_irq1(o_irq1),
    .o_conv_start(o_conv_start), .i_conv_done(i_conv_done), .i_conv_data(i_conv_data),
    .o_gain(o_gain), .o_diff(o_diff), .o_input_sel(o_input_sel));
  amc_conv_model conv (.i_clock(i_clock), .i_start(o_conv_start), .i_lag(lag), .i_sample(sample),
    .o_done(i_conv_done), .o_data(i_conv_data));

  always #12.5 i_clock = ~i_clock;

  // Launch count catches extra or missing starts
  always @(posedge i_clock)
    if (o_conv_start === 1'b1)
      starts++;

  ////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  function automatic logic [3:0] exp_sel(input logic [15:0] v);
    return {v[3] & ~v[4], v[2:0]};
  endfunction : exp_sel

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
    @(posedge i_clock);
    #2;
    i_addr = a;
    i_wdata = v;
    i_wr = 1'b1;
    @(posedge i_clock);
    #2;
    i_wr = 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [15:0] v);
    @(posedge i_clock);
    #2;
    i_addr = a;
    i_rd = 1'b1;
    @(posedge i_clock);
    #2;
    i_rd = 1'b0;
    v = o_rdata;
  endtask : rd_reg

  // Bounded poll of one flag; a stuck flag ends the run
  task automatic poll(input int b, input logic val);
    n = 0;
    do
    begin
      rd_reg(8'h05, r);
      n++;
    end while (r[b] !== val && n < 100);
    if (r[b] !== val)
    begin
      check("poll bound", 16'h0001, 16'h0000);
      report_and_stop();
    end
  endtask : poll

  task automatic ack(input logic lvl, input logic [7:0] exp);
    @(posedge i_clock);
    #2;
    i_ack = 1'b1;
    i_ack_level = lvl;
    @(posedge i_clock);
    #2;
    i_ack = 1'b0;
    check("vector", o_vector, exp);
    check("cleared request", lvl ? o_irq1 : o_irq0, 16'h0000);
  endtask : ack

  // One conversion in the mode that s selects
  task automatic convert(input logic [15:0] s);
    sample = $random(seed);
    lag = $random(seed);
    s0 = starts;
    wr_reg(8'h00, s);
    if (!s[7])
    begin
      poll(0, 1'b0);
      check("settle length", n >= SETTLE / 2 - 1 && n <= SETTLE / 2 + 1, 16'h0001);
      check("start from setup", starts - s0, 16'h0000);
      wr_reg(8'h07, 16'h00ff);
      wr_reg(8'h07, 16'h00ff);
    end
    else
    begin
      rd_reg(8'h05, r);
      check("busy in settle", r[1], 16'h0001);
    end
    poll(1, 1'b0);
    check("launch count", starts - s0, 16'h0001);
    rd_reg(8'h02, r);
    check("result", r, s[8] ? prev : sample);
    prev = sample;
    check("conv request", o_irq0, s[9]);
    check("settle request", o_irq1, s[9] & ~s[7]);
    if (s[9])
      ack(1'b0, 8'ha4);
    if (s[9] && !s[7])
      ack(1'b1, 8'ha5);
  endtask : convert

  initial
  begin
    seed = 43;
    prev = 16'h0000;
    i_clock = 1'b0;
    i_srst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_ack = 1'b0;
    i_ack_level = 1'b0;
    i_addr = 8'h00;
    i_wdata = 16'h0000;
    sample = 16'h0000;
    lag = 4'h0;
    repeat (3) @(posedge i_clock);
    #2;
    i_srst = 1'b0;
    // The identification unlock place is never written
    foreach (rst_addr[k])
    begin
      rd_reg(rst_addr[k], r);
      check("reset read", r, 16'h0000);
    end
    wr_reg(8'h05, 16'hffff);
    rd_reg(8'h05, r);
    check("flags read only", r, 16'h0000);
    wr_reg(8'h09, 16'h00a5);
    rd_reg(8'h09, r);
    check("vector base", r, 16'h00a4);
    // Result register is host-writable as well
    wr_reg(8'h02, 16'h5a3c);
    rd_reg(8'h02, r);
    check("result host write", r, 16'h5a3c);
    $display("Test reset and map done");
    // Every gain code and input mode, random rest
    for (int i = 0; i < 8; i++)
    begin
      d = (i == 7) ? 16'hffff : $random(seed);
      d[6:5] = i[1:0];
      d[4] = i[2];
      d[9] = 1'b0;
      d[7] = 1'b0;
      wr_reg(8'h00, d);
      rd_reg(8'h00, r);
      check("setup", r, d & 16'h03ff);
      check("gain", o_gain, d[6:5]);
      check("diff", o_diff, d[4]);
      check("select", o_input_sel, exp_sel(d));
    end
    $display("Test setup fields done");
    foreach (runs[k])
      convert(runs[k]);
    $display("Test conversions done");
    report_and_stop();
  end
endmodule : tb

bind amc_control amc_control_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_mon (.i_clock(i_clock),
  .i_srst(i_srst), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata),
  .i_ack(i_ack), .i_ack_level(i_ack_level), .o_vector(o_vector), .o_irq0(o_irq0), .o_irq1(o_irq1),
  .o_conv_start(o_conv_start), .i_conv_done(i_conv_done), .i_conv_data(i_conv_data),
  .o_gain(o_gain), .o_diff(o_diff), .o_input_sel(o_input_sel));
